// File: include/adsq_pkg.sv
// shared constants and types for the converter scan sequencer
package adsq_pkg;

   // register indices; byte address is four times the index
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_CONTROL_STATUS = 8'h30;
   localparam logic [7:0] IDX_CLOCK_RATE = 8'h32;
   localparam logic [7:0] IDX_POWER_OPTION = 8'h34;
   localparam logic [7:0] IDX_RESULT_FIRST = 8'h40;
   localparam logic [7:0] IDX_RESULT_LAST = 8'h4f;

   // control/status fields
   localparam int CTL_DONE_BIT = 7;
   localparam int CTL_EIGHT_CONVERSION_SELECT_BIT = 6;
   localparam int CTL_SCAN_BIT = 5;
   localparam int CTL_MULTI_CHANNEL_SELECT_BIT = 4;
   localparam logic [6:0] CTL_RESET = 7'h00;

   // clock rate select fields
   localparam int RATE_HALF_BIT = 0;
   localparam logic [7:0] RATE_RESET = 8'h00;

   // power option fields
   localparam int OPT_POWER_BIT = 0;
   localparam int OPT_RC_BIT = 1;
   localparam int OPT_DELAY_BIT = 2;
   localparam logic [2:0] OPT_RESET = 3'h4;

   // channel codes
   localparam logic [3:0] CHAN_RESERVED_FIRST = 4'h7;
   localparam logic [3:0] CHAN_RESERVED_LAST = 4'hb;
   localparam logic [3:0] CHAN_LOW_REF = 4'hd;

   // result layout
   localparam int NUM_RESULTS = 8;
   localparam int RESULT_W = 10;

   // timing
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
   localparam int STOP_RECOVERY_US = 100;
   localparam int STOP_RECOVERY_CYCLES =
      (STOP_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARM,
      ST_CONVERT,
      ST_SUSPEND,
      ST_RECOVER
   } adsq_state_type;

endpackage

// File: hw/adsq_scan_plan.sv
// channel and result slot planning plus conversion rate divider
`timescale 1ns/10ps
module adsq_scan_plan
   import adsq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // mode
   input wire logic eight_conversion_select,
   input wire logic multi_channel_select,
   input wire logic [3:0] channel_select,
   input wire logic half_rate_clock_select,
   // sequence position
   input wire logic [2:0] step,
   // plan
   output logic [3:0] plan_channel,
   output logic [2:0] plan_slot,
   output logic plan_last,
   output logic rate_tick
);

   logic half_phase;
   logic [3:0] raw_channel;
   logic reserved_code;

   assign raw_channel = !multi_channel_select ? channel_select :
                        eight_conversion_select ? {channel_select[3], step} :
                        {channel_select[3:2], step[1:0]};

   assign reserved_code = (raw_channel >= CHAN_RESERVED_FIRST) &&
                          (raw_channel <= CHAN_RESERVED_LAST);
   assign plan_channel = reserved_code ? CHAN_LOW_REF : raw_channel;

   // slots five to eight for four
   assign plan_slot = eight_conversion_select ? step : {1'b1, step[1:0]};

   assign plan_last = eight_conversion_select ? (step == 3'h7) : (step[1:0] == 2'h3);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_phase <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
      end
   end

   assign rate_tick = half_rate_clock_select ? half_phase : 1'b1;

endmodule

// File: hw/adsq_top.sv
// scan sequencer for a multiplexed successive-approximation converter
//
// Operation
// - four-group single scan fills results five to eight, then stops.
// - four-group continuous scan keeps overwriting results five to eight.
// - eight-group single scan: pin n to result n+1, then halt.
// - eight-group continuous scan overwrites results one to eight endlessly.
// - power option bit clear removes converter power; set enables it.
// - clock source bit picks system clock or internal RC oscillator.
// - on system clock, all stepping is synchronous to that clock.
// - stop or wait suspends current channel; it is resampled afterwards.
// - stop powers down analog parts; delayed exit waits for recovery.
// - control write clears flag, aborts, restarts with new settings.
// - done flag sets after first full cycle, holds until control write.
// - control byte: flag, eight-select, scan, multi, four channel bits.
// - eight-select picks eight conversions, otherwise four.
// - scan bit picks endless conversion, otherwise one cycle and stop.
// - multi bit scans a group, otherwise repeats one channel.
// - group mode ignores the low channel bits.
// - rate bit 0 halves the conversion clock; upper bits read zero.
// - single channel: four into five to eight, eight into one to eight.
// - results are 10 bits: high byte, then two bits at 7:6.
// - sixteen channel codes; reserved codes connect low reference.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module adsq_top
   import adsq_pkg::*;
#(
   parameter int RECOVERY_CYCLES = STOP_RECOVERY_CYCLES
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // register bus write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // register bus write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // low power state of the system
   input wire logic stop_mode,
   input wire logic wait_mode,
   // analog core
   output logic converter_power_on,
   output logic rc_clock_source_select,
   output logic rc_osc_enable,
   output logic comparator_enable,
   output logic conv_tick,
   output logic [3:0] conv_channel,
   output logic conv_start,
   output logic conv_abort,
   input wire logic conv_done,
   input wire logic [RESULT_W-1:0] conv_result
);

   adsq_state_type state, next_state;
   logic [2:0] step, next_step;
   logic next_start, next_abort, store_result, set_done;
   logic [6:0] control;
   logic sequence_done_flag;
   logic half_rate_clock_select;
   logic [2:0] power_option;
   logic stop_seen;
   logic [12:0] recover_count;
   logic [RESULT_W-1:0] results [NUM_RESULTS];

   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0] w_byte_q;
   logic w_lane_q;

   // word index decode, shared by read and write sides
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      hit = addr[ADDR_W-1:2] == {2'b00, idx};
   endfunction

   function automatic logic result_hit(input logic [ADDR_W-1:0] addr);
      result_hit = (addr[ADDR_W-1:2] >= {2'b00, IDX_RESULT_FIRST}) &&
                   (addr[ADDR_W-1:2] <= {2'b00, IDX_RESULT_LAST});
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hit(addr, IDX_CONTROL_STATUS) || hit(addr, IDX_CLOCK_RATE) ||
               hit(addr, IDX_POWER_OPTION) || result_hit(addr);
   endfunction

   // ---------------- write channel ----------------
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_held || aw_fire;
   wire have_w = w_held || w_fire;
   wire do_write = have_aw && have_w && !s_axi_bvalid;
   wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
   wire [7:0] wr_byte = w_held ? w_byte_q : s_axi_wdata[7:0];
   wire wr_lane = w_held ? w_lane_q : s_axi_wstrb[0];
   wire wr_en = do_write && wr_lane;
   wire ctl_wr = wr_en && hit(wr_addr, IDX_CONTROL_STATUS);
   wire rate_wr = wr_en && hit(wr_addr, IDX_CLOCK_RATE);
   wire opt_wr = wr_en && hit(wr_addr, IDX_POWER_OPTION);

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_byte_q <= 8'h00;
         w_lane_q <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end
         aw_held <= have_aw && !do_write;
         w_held <= have_w && !do_write;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- software registers ----------------
   // the control byte resets undefined; zero is chosen so the block starts idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= CTL_RESET;
         half_rate_clock_select <= RATE_RESET[RATE_HALF_BIT];
         power_option <= OPT_RESET;
      end else begin
         if (ctl_wr) begin
            control <= wr_byte[6:0];
         end
         if (rate_wr) begin
            half_rate_clock_select <= wr_byte[RATE_HALF_BIT];
         end
         if (opt_wr) begin
            power_option <= wr_byte[2:0];
         end
      end
   end

   wire eight_conversion_select = control[CTL_EIGHT_CONVERSION_SELECT_BIT];
   wire continuous_scan_select = control[CTL_SCAN_BIT];
   wire multi_channel_select = control[CTL_MULTI_CHANNEL_SELECT_BIT];
   wire stop_exit_delay_enable = power_option[OPT_DELAY_BIT];
   wire low_power = stop_mode || wait_mode;

   assign converter_power_on = power_option[OPT_POWER_BIT];
   assign rc_clock_source_select = power_option[OPT_RC_BIT];
   assign comparator_enable = converter_power_on && !stop_mode;
   assign rc_osc_enable = converter_power_on && rc_clock_source_select && !stop_mode;

   // ---------------- scan plan ----------------
   logic [3:0] plan_channel;
   logic [2:0] plan_slot;
   logic plan_last;
   logic rate_tick;

   adsq_scan_plan u_plan (
      .aclk(aclk),
      .aresetn(aresetn),
      .eight_conversion_select(eight_conversion_select),
      .multi_channel_select(multi_channel_select),
      .channel_select(control[3:0]),
      .half_rate_clock_select(half_rate_clock_select),
      .step(step),
      .plan_channel(plan_channel),
      .plan_slot(plan_slot),
      .plan_last(plan_last),
      .rate_tick(rate_tick)
   );

   // stepping tick on system clock only
   assign conv_tick = (state == ST_CONVERT) && !rc_clock_source_select && rate_tick;

   // ---------------- sequence control ----------------
   wire recover_over = recover_count == 13'h0000;
   wire [2:0] step_after = plan_last ? 3'h0 : 3'(step + 3'h1);

   always_comb begin
      next_state = state;
      next_step = step;
      next_start = 1'b0;
      next_abort = 1'b0;
      store_result = 1'b0;
      set_done = 1'b0;
      if (ctl_wr) begin
         next_abort = (state == ST_CONVERT);
         next_step = 3'h0;
         next_state = ST_ARM;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_ARM: begin
               if (low_power) begin
                  next_state = ST_SUSPEND;
               end else if (converter_power_on) begin
                  next_start = 1'b1;
                  next_state = ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (!converter_power_on) begin
                  // power removal kills the conversion; it restarts on power
                  next_abort = 1'b1;
                  next_state = ST_ARM;
               end else if (conv_done) begin
                  store_result = 1'b1;
                  next_step = step_after;
                  if (!plan_last) begin
                     next_state = ST_ARM;
                  end else begin
                     set_done = 1'b1;
                     next_state = continuous_scan_select ? ST_ARM : ST_IDLE;
                  end
               end else if (low_power) begin
                  next_abort = 1'b1;
                  next_state = ST_SUSPEND;
               end
            end
            ST_SUSPEND: begin
               if (!low_power) begin
                  next_state = (stop_seen && stop_exit_delay_enable) ? ST_RECOVER : ST_ARM;
               end
            end
            ST_RECOVER: begin
               if (low_power) begin
                  next_state = ST_SUSPEND;
               end else if (recover_over) begin
                  next_state = ST_ARM;
               end
            end
            default: begin
               next_state = ST_IDLE;
               next_step = 3'h0;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         step <= 3'h0;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conv_channel <= 4'h0;
      end else begin
         state <= next_state;
         step <= next_step;
         conv_start <= next_start;
         conv_abort <= next_abort;
         if (next_start) begin
            conv_channel <= plan_channel;
         end
      end
   end

   // stop is remembered until the sequence has resumed after it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_seen <= 1'b0;
         recover_count <= 13'h0000;
      end else begin
         if (stop_mode) begin
            stop_seen <= 1'b1;
         end else if (next_state == ST_ARM || next_state == ST_IDLE) begin
            stop_seen <= 1'b0;
         end
         if (state == ST_SUSPEND) begin
            recover_count <= 13'(RECOVERY_CYCLES - 1);
         end else if (!recover_over) begin
            recover_count <= recover_count - 13'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sequence_done_flag <= 1'b0;
      end else if (ctl_wr) begin
         sequence_done_flag <= 1'b0;
      end else if (set_done) begin
         sequence_done_flag <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_RESULTS; i++) begin
            results[i] <= '0;
         end
      end else if (store_result) begin
         results[plan_slot] <= conv_result;
      end
   end

   // ---------------- read channel ----------------
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [2:0] rd_slot = s_axi_araddr[5:3];
   wire [RESULT_W-1:0] rd_result = results[rd_slot];
   wire [7:0] rd_result_byte = s_axi_araddr[2] ? {rd_result[1:0], 6'h00} : rd_result[9:2];
   wire [7:0] rd_byte =
      hit(s_axi_araddr, IDX_CONTROL_STATUS) ? {sequence_done_flag, control} :
      hit(s_axi_araddr, IDX_CLOCK_RATE) ? {7'h00, half_rate_clock_select} :
      hit(s_axi_araddr, IDX_POWER_OPTION) ? {5'h00, power_option} :
      result_hit(s_axi_araddr) ? rd_result_byte : 8'h00;

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// File: dv/adsq_sva.sv
// concurrent checks on the scan sequencer ports
`timescale 1ns/10ps
module adsq_sva #(
   parameter int RECOVERY_CYCLES = 8
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // low power and analog core
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic converter_power_on,
   input wire logic rc_clock_source_select,
   input wire logic rc_osc_enable,
   input wire logic comparator_enable,
   input wire logic conv_tick,
   input wire logic [3:0] conv_channel,
   input wire logic conv_start
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_rc_osc_tie: assert property (
      rc_osc_enable == (converter_power_on && rc_clock_source_select && !stop_mode))
      else $error("rc oscillator enable wrong");
   a_comp_tie: assert property (
      comparator_enable == (converter_power_on && !stop_mode))
      else $error("comparator enable wrong");
   a_no_tick_rc: assert property (
      rc_clock_source_select |-> !conv_tick)
      else $error("system ticks while rc clock chosen");
   a_start_unpowered: assert property (
      !converter_power_on && !$past(converter_power_on) |-> !conv_start)
      else $error("start while unpowered");
   a_start_lowpow: assert property (
      $past(stop_mode) || $past(wait_mode) |-> !conv_start)
      else $error("start during low power");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_channel_held: assert property (
      !conv_start && !$past(conv_start) |-> $stable(conv_channel))
      else $error("channel moved between starts");
   a_reserved_code: assert property (
      $past(conv_start) |-> !(conv_channel inside {[4'h7:4'hb]}))
      else $error("reserved channel code reached the mux");
endmodule

// File: dv/adsq_core_model.sv
// behavioural analog core: one sampled result per start
`timescale 1ns/10ps
module adsq_core_model (
   // clock
   input wire logic aclk,
   // sequencer side
   input wire logic converter_power_on,
   input wire logic conv_tick,
   input wire logic [3:0] conv_channel,
   input wire logic conv_start,
   input wire logic conv_abort,
   output logic conv_done,
   output logic [9:0] conv_result,
   // bench controls: low result bits and ticks per conversion
   input wire logic [5:0] tag,
   input wire logic [31:0] ticks_needed
);
   logic busy = 1'b0;
   logic [3:0] held = 4'h0;
   logic [9:0] last = 10'h000;
   int count = 0;
   // steps only on ticks, drops the sample on abort or power loss
   always @(posedge aclk) begin
      conv_done <= 1'b0;
      if (conv_start) begin
         busy <= 1'b1;
         count <= 0;
         held <= conv_channel;
      end else if (conv_abort || !converter_power_on) begin
         busy <= 1'b0;
      end else if (busy && conv_tick) begin
         count <= count + 1;
         if (count + 1 >= ticks_needed) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            last <= {held, tag};
         end
      end
   end
   // inverted outside the done pulse: never the last value
   assign conv_result = conv_done ? last : ~last;
endmodule

// File: dv/testbench.sv
// self-checking bench for the converter scan sequencer
`timescale 1ns/10ps
module testbench;
   import adsq_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, conv_channel;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic stop_mode, wait_mode, converter_power_on, rc_clock_source_select, rc_osc_enable;
   logic comparator_enable, conv_tick, conv_start, conv_abort, conv_done;
   logic [RESULT_W-1:0] conv_result;
   logic [5:0] tag;
   logic [7:0] modes [6] = '{8'h17, 8'h3e, 8'h5f, 8'h77, 8'h23, 8'h6c};
   int lat, miscompares, cmp_count, starts, aborts, dones, cyc, t0, span;
   adsq_top #(.RECOVERY_CYCLES(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .wait_mode, .converter_power_on,
      .rc_clock_source_select, .rc_osc_enable, .comparator_enable, .conv_tick, .conv_channel,
      .conv_start, .conv_abort, .conv_done, .conv_result);
   adsq_core_model core (.aclk, .converter_power_on, .conv_tick, .conv_channel, .conv_start,
      .conv_abort, .conv_done, .conv_result, .tag, .ticks_needed(lat));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (conv_start === 1'b1) begin
         starts <= starts + 1;
         t0 <= cyc;
      end
      if (conv_abort === 1'b1) aborts <= aborts + 1;
      if (conv_done === 1'b1) begin
         dones <= dones + 1;
         span <= cyc - t0;
      end
   end
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic expire(input string what);
      miscompares++;
      $display("FAIL %s expected answer seen timeout", what);
      wrap_up();
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] rsp;
      @(posedge aclk);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      for (int n = 0; !b; n++) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (n > 100) expire("write");
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(rsp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] d);
      logic ar, r;
      logic [1:0] rsp;
      @(posedge aclk);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 1'b0;
      for (int n = 0; !r; n++) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rsp = s_axi_rresp;
         d = s_axi_rdata;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (n > 100) expire("read");
      end
      s_axi_rready <= 1'b0;
      chk("rresp", 32'(rsp), 32'(er));
   endtask
   task automatic wait_flag;
      logic [31:0] d;
      for (int i = 0; i < 600; i++) begin
         rd(IDX_CONTROL_STATUS, RESP_OKAY, d);
         if (d[CTL_DONE_BIT] === 1'b1) return;
      end
      expire("done flag");
   endtask
   function automatic logic [3:0] mapped(input logic [3:0] c);
      return (c >= CHAN_RESERVED_FIRST && c <= CHAN_RESERVED_LAST) ? CHAN_LOW_REF : c;
   endfunction
   task automatic chk_slots(input logic [7:0] ctl, input logic [5:0] tg);
      logic [31:0] d;
      logic [3:0] ch;
      logic [9:0] e;
      int n;
      n = ctl[CTL_EIGHT_CONVERSION_SELECT_BIT] ? 8 : 4;
      for (int k = 0; k < n; k++) begin
         ch = !ctl[CTL_MULTI_CHANNEL_SELECT_BIT] ? ctl[3:0] : (n == 8 ? {ctl[3], 3'(k)} : {ctl[3:2], 2'(k)});
         e = {mapped(ch), tg};
         rd(IDX_RESULT_FIRST + 8'(2 * (k + 8 - n)), RESP_OKAY, d);
         chk("result high", d, {24'h0, e[9:2]});
         rd(IDX_RESULT_FIRST + 8'(2 * (k + 8 - n) + 1), RESP_OKAY, d);
         chk("result low", d, {24'h0, e[1:0], 6'h00});
      end
   endtask
   task automatic t_reset;
      logic [31:0] d;
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_CONTROL_STATUS, RESP_OKAY, d);
      chk("control reset", d, 32'h0);
      rd(IDX_POWER_OPTION, RESP_OKAY, d);
      chk("option reset", d, 32'h4);
      wr(IDX_CLOCK_RATE, 8'hff, RESP_OKAY);
      rd(IDX_CLOCK_RATE, RESP_OKAY, d);
      chk("rate bits", d, 32'h1);
      wr(IDX_CLOCK_RATE, 8'h00, RESP_OKAY);
      wr(8'hff, 8'h5a, RESP_SLVERR);
      rd(8'hff, RESP_SLVERR, d);
      chk("unmapped data", d, 32'h0);
      wr(IDX_RESULT_FIRST, 8'hff, RESP_OKAY);
      rd(IDX_RESULT_FIRST, RESP_OKAY, d);
      chk("result read only", d, 32'h0);
      $display("test reset and registers done");
   endtask
   task automatic t_power;
      wr(IDX_POWER_OPTION, 8'h07, RESP_OKAY);
      chk("rc osc on", 32'(rc_osc_enable), 32'h1);
      // no conversion runs on the oscillator, so no wait
      wr(IDX_POWER_OPTION, 8'h05, RESP_OKAY);
      chk("rc osc off", 32'(rc_osc_enable), 32'h0);
      chk("power on", 32'(converter_power_on), 32'h1);
      repeat (2000) @(posedge aclk);
      $display("test power and clock done");
   endtask
   task automatic t_scan(input logic [7:0] ctl);
      logic [31:0] d;
      int s0;
      tag <= 6'h15;
      wr(IDX_CONTROL_STATUS, ctl, RESP_OKAY);
      wait_flag();
      chk_slots(ctl, 6'h15);
      s0 = starts;
      if (ctl[CTL_SCAN_BIT]) begin
         tag <= 6'h2a;
         s0 = dones;
         for (int i = 0; dones < s0 + 9; i++) begin
            @(posedge aclk);
            if (i > 3000) expire("rescan");
         end
         chk_slots(ctl, 6'h2a);
         rd(IDX_CONTROL_STATUS, RESP_OKAY, d);
         chk("flag held", 32'(d[CTL_DONE_BIT]), 32'h1);
      end else begin
         repeat (100) @(posedge aclk);
         chk("halted", starts, s0);
      end
      $display("test scan %h done", ctl);
   endtask
   task automatic t_half_rate;
      wr(IDX_CLOCK_RATE, 8'h01, RESP_OKAY);
      wr(IDX_CONTROL_STATUS, 8'h13, RESP_OKAY);
      wait_flag();
      chk("half rate span", 32'(span >= 2 * lat - 2), 32'h1);
      wr(IDX_CLOCK_RATE, 8'h00, RESP_OKAY);
      $display("test half rate done");
   endtask
   task automatic t_abort;
      logic [31:0] d;
      int a0;
      lat = 40;
      wr(IDX_CONTROL_STATUS, 8'h42, RESP_OKAY);
      repeat (10) @(posedge aclk);
      a0 = aborts;
      wr(IDX_CONTROL_STATUS, 8'h4c, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("abort pulse", aborts, a0 + 1);
      rd(IDX_CONTROL_STATUS, RESP_OKAY, d);
      chk("flag cleared", d, 32'h4c);
      wait_flag();
      chk_slots(8'h4c, tag);
      lat = 6;
      $display("test abort done");
   endtask
   task automatic t_low_power;
      int a0, s0;
      lat = 20;
      wr(IDX_CONTROL_STATUS, 8'h03, RESP_OKAY);
      repeat (10) @(posedge aclk);
      a0 = aborts;
      stop_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("comparator off", 32'(comparator_enable), 32'h0);
      s0 = starts;
      repeat (30) @(posedge aclk);
      chk("no start in stop", starts, s0);
      chk("suspended", aborts, a0 + 1);
      // delayed exit: no software wait owed
      stop_mode <= 1'b0;
      repeat (12) @(posedge aclk);
      wait_mode <= 1'b1;
      repeat (20) @(posedge aclk);
      wait_mode <= 1'b0;
      wait_flag();
      chk_slots(8'h03, tag);
      lat = 6;
      $display("test low power done");
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h1;
      stop_mode = 1'b0;
      wait_mode = 1'b0;
      tag = 6'h00;
      lat = 6;
      t_reset();
      t_power();
      foreach (modes[i]) t_scan(modes[i]);
      t_half_rate();
      t_abort();
      t_low_power();
      t_reset();
      wrap_up();
   end
   initial begin
      repeat (100000) @(posedge aclk);
      expire("run length");
   end
endmodule
bind adsq_top adsq_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) sva (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .stop_mode, .wait_mode, .converter_power_on, .rc_clock_source_select,
   .rc_osc_enable, .comparator_enable, .conv_tick, .conv_channel, .conv_start);
